// ===== rld_core.sv
// Repeat loop control and iterative divide unit
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module rld_core #(
  parameter int LIT_W = rld_pkg::LIT_WIDTH
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic        REPEAT_VALID,
  input  wire logic        REPEAT_USE_REG,
  input  wire logic [19:0] REPEAT_LITERAL,
  input  wire logic [31:0] REPEAT_REG_VALUE,
  input  wire logic        TARGET_DONE,
  input  wire logic        IRQ_ENTRY,
  input  wire logic        IRQ_RETURN,
  input  wire logic        STACKED_LOOP_ACTIVE,
  output logic             STACK_LOOP_ACTIVE,
  output logic             PC_HOLD,
  output logic             FETCH_BUBBLE,
  output logic             LOOP_ACTIVE,
  input  wire logic        DIV_VALID,
  input  wire logic [2:0]  DIV_MODE,
  input  wire logic        DIV_SIGNED,
  input  wire logic        DIV_FIRST,
  input  wire logic [31:0] DIV_DIVIDEND,
  input  wire logic [31:0] DIV_DIVISOR,
  input  wire logic [31:0] DIV_REM_IN,
  input  wire logic [31:0] DIV_QUO_IN,
  input  wire logic [3:0]  DIV_DEST,
  output logic             WREG_WE,
  output logic      [3:0]  WREG_QUO_ADDR,
  output logic      [3:0]  WREG_REM_ADDR,
  output logic      [31:0] WREG_QUO_DATA,
  output logic      [31:0] WREG_REM_DATA,
  output logic             MATH_TRAP
);
  logic [31:0] count_q, count_d;
  logic        active_q, active_d;
  logic        saved_q, saved_d;
  logic [1:0]  bubble_q, bubble_d;
  logic        div_err_q, div_err_d;
  logic        trap_q, trap_d;
  logic        we_q, we_d;
  logic [3:0]  qa_q, qa_d, ra_q, ra_d;
  logic [31:0] qd_q, qd_d, rd_q, rd_d;
  logic [31:0] rdata_q, rdata_d;
  logic        bub_out_q, bub_out_d;

  localparam int WORD_W = 32;
  localparam int STEP_S = WORD_W / rld_pkg::ITER_SHORT + 1;
  localparam int STEP_L = WORD_W / rld_pkg::ITER_LONG + 1;

  logic [31:0] load_value;
  logic        long_div;
  logic        div_neg_a, div_neg_b;
  logic [31:0] mag_a, mag_b;
  logic [31:0] step_rem_in, step_quo_in;
  logic [31:0] step_rem_s, step_quo_s, step_rem_l, step_quo_l;
  logic [5:0]  shifts_s, shifts_l;

  function automatic logic [31:0] abs32(input logic [31:0] v, input logic sgn);
    abs32 = (sgn && v[31]) ? (~v + 32'h0000_0001) : v;
  endfunction : abs32

  // Shifts owed by this pass; the loop counter tells which pass it is, and software saves it across interrupts
  function automatic logic [5:0] pass_shifts(input logic [31:0] cnt, input int iters, input int step);
    int done;
    done = 0;
    if (cnt < 32'(iters)) begin
      done = (iters - 1 - int'(cnt)) * step;
    end
    if (done >= WORD_W) begin
      pass_shifts = 6'h00;
    end else if (WORD_W - done < step) begin
      pass_shifts = 6'(WORD_W - done);
    end else begin
      pass_shifts = 6'(step);
    end
  endfunction : pass_shifts

  // Loop count source: zero-extended literal or register contents
  assign load_value = REPEAT_USE_REG ? REPEAT_REG_VALUE : {{(32 - LIT_W){1'b0}}, REPEAT_LITERAL[LIT_W-1:0]};
  assign long_div   = (DIV_MODE == rld_pkg::DIV_FRAC_32_32) || (DIV_MODE == rld_pkg::DIV_INT_32_32);

  // Repeat loop control
  always_comb begin
    count_d  = count_q;
    active_d = active_q;
    saved_d  = saved_q;
    bubble_d = bubble_q;
    if (bubble_q != 2'h0) begin
      bubble_d = bubble_q - 2'h1;
    end
    if (REPEAT_VALID) begin
      count_d  = load_value;
      active_d = (load_value != 32'h0000_0000);
    end else if (IRQ_ENTRY) begin
      saved_d  = active_q;
      active_d = 1'b0;
    end else if (IRQ_RETURN) begin
      // Restore flag only if the loop still has count; cleared counter ends it
      active_d = STACKED_LOOP_ACTIVE && (count_q != 32'h0000_0000);
      bubble_d = 2'(rld_pkg::BUBBLES_RETURN);
    end else if (TARGET_DONE && active_q) begin
      count_d  = count_q - 32'h0000_0001;
      active_d = (count_q != 32'h0000_0001);
    end
    if (REG_WR && REG_ADDR == rld_pkg::ADDR_LOOP_COUNTER && !REPEAT_VALID) begin
      count_d = REG_WDATA;
      if (REG_WDATA == 32'h0000_0000) begin
        active_d = 1'b0;
      end
    end
    bub_out_d = (bubble_d != 2'h0);
  end

  // Divider datapath; signed forms work on magnitudes and fix signs at the end
  assign div_neg_b = DIV_SIGNED && DIV_DIVISOR[31];
  assign mag_b     = abs32(DIV_DIVISOR, DIV_SIGNED);
  always_comb begin
    logic [31:0] ext;
    ext = DIV_DIVIDEND;
    if (DIV_MODE == rld_pkg::DIV_INT_16_16 || DIV_MODE == rld_pkg::DIV_FRAC_16_16) begin
      ext = {{16{DIV_SIGNED & DIV_DIVIDEND[15]}}, DIV_DIVIDEND[15:0]};
    end
    // Sign taken after extension, so 16/16 forms look at bit 15 of the dividend
    div_neg_a = DIV_SIGNED && ext[31];
    mag_a     = abs32(ext, DIV_SIGNED);
    if (DIV_FIRST) begin
      step_rem_in = 32'h0000_0000;
      step_quo_in = mag_a;
    end else begin
      step_rem_in = DIV_REM_IN;
      step_quo_in = DIV_QUO_IN;
    end
  end

  assign shifts_s = pass_shifts(count_q, rld_pkg::ITER_SHORT, STEP_S);
  assign shifts_l = pass_shifts(count_q, rld_pkg::ITER_LONG, STEP_L);

  rld_div_step #(.STEP_BITS(STEP_S)) u_step_short (
    .rem_in  (step_rem_in),
    .quo_in  (step_quo_in),
    .divisor (mag_b),
    .shifts  (shifts_s),
    .rem_out (step_rem_s),
    .quo_out (step_quo_s)
  );
  rld_div_step #(.STEP_BITS(STEP_L)) u_step_long (
    .rem_in  (step_rem_in),
    .quo_in  (step_quo_in),
    .divisor (mag_b),
    .shifts  (shifts_l),
    .rem_out (step_rem_l),
    .quo_out (step_quo_l)
  );

  // Each step except a first step with a zero divisor, which traps, writes back the partial pair so an interrupt loses nothing
  always_comb begin
    we_d      = 1'b0;
    qa_d      = qa_q;
    ra_d      = ra_q;
    qd_d      = qd_q;
    rd_d      = rd_q;
    trap_d    = 1'b0;
    div_err_d = div_err_q;
    if (DIV_VALID) begin
      we_d = 1'b1;
      qa_d = DIV_DEST;
      ra_d = DIV_DEST + 4'h1;
      qd_d = long_div ? step_quo_l : step_quo_s;
      rd_d = long_div ? step_rem_l : step_rem_s;
      if (DIV_FIRST && DIV_DIVISOR == 32'h0000_0000) begin
        we_d      = 1'b0;
        trap_d    = 1'b1;
        div_err_d = 1'b1;
      end else if (count_q == 32'h0000_0000) begin
        // Last pass: the pair held magnitudes so far, so signs are applied once here
        if (div_neg_a ^ div_neg_b) begin
          qd_d = ~qd_d + 32'h0000_0001;
        end
        if (div_neg_a) begin
          rd_d = ~rd_d + 32'h0000_0001;
        end
      end
    end
    // A trap in the same cycle as the clear keeps the flag set
    if (REG_WR && REG_ADDR == rld_pkg::ADDR_INT_CTRL_FOUR && !REG_WDATA[rld_pkg::DIV_ERR_BIT] && !trap_d) begin
      div_err_d = 1'b0;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        rld_pkg::ADDR_LOOP_COUNTER: rdata_d = count_q;
        rld_pkg::ADDR_STATUS:       rdata_d[rld_pkg::LOOP_ACTIVE_BIT] = active_q;
        rld_pkg::ADDR_INT_CTRL_FOUR: rdata_d[rld_pkg::DIV_ERR_BIT] = div_err_q;
        default:                    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      count_q   <= rld_pkg::LOOP_COUNTER_RST;
      active_q  <= 1'b0;
      saved_q   <= 1'b0;
      bubble_q  <= 2'h0;
      div_err_q <= 1'b0;
      trap_q    <= 1'b0;
      we_q      <= 1'b0;
      qa_q      <= 4'h0;
      ra_q      <= 4'h0;
      qd_q      <= 32'h0000_0000;
      rd_q      <= 32'h0000_0000;
      rdata_q   <= 32'h0000_0000;
      bub_out_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      active_q  <= active_d;
      saved_q   <= saved_d;
      bubble_q  <= bubble_d;
      div_err_q <= div_err_d;
      trap_q    <= trap_d;
      we_q      <= we_d;
      qa_q      <= qa_d;
      ra_q      <= ra_d;
      qd_q      <= qd_d;
      rd_q      <= rd_d;
      rdata_q   <= rdata_d;
      bub_out_q <= bub_out_d;
    end
  end

  assign REG_RDATA         = rdata_q;
  assign LOOP_ACTIVE       = active_q;
  assign PC_HOLD           = active_q;
  assign STACK_LOOP_ACTIVE = saved_q;
  assign FETCH_BUBBLE      = bub_out_q;
  assign WREG_WE           = we_q;
  assign WREG_QUO_ADDR     = qa_q;
  assign WREG_REM_ADDR     = ra_q;
  assign WREG_QUO_DATA     = qd_q;
  assign WREG_REM_DATA     = rd_q;
  assign MATH_TRAP         = trap_q;
endmodule : rld_core

// ===== rld_pkg.sv
// Package with constants for the repeat loop and divide unit
package rld_pkg;
  localparam logic [3:0]  ADDR_LOOP_COUNTER = 4'h0;
  localparam logic [3:0]  ADDR_STATUS       = 4'h4;
  localparam logic [3:0]  ADDR_INT_CTRL_FOUR = 4'h8;
  localparam logic [31:0] LOOP_COUNTER_RST  = 32'h0000_0000;
  localparam int          LOOP_ACTIVE_BIT   = 4;
  localparam int          DIV_ERR_BIT       = 0;
  localparam int          LIT_WIDTH         = 20;
  localparam int          ITER_SHORT        = 6;
  localparam int          ITER_LONG         = 10;
  localparam int          BUBBLES_RETURN    = 2;
  localparam logic [2:0]  DIV_FRAC_16_16    = 3'h0;
  localparam logic [2:0]  DIV_FRAC_32_16    = 3'h1;
  localparam logic [2:0]  DIV_FRAC_32_32    = 3'h2;
  localparam logic [2:0]  DIV_INT_16_16     = 3'h3;
  localparam logic [2:0]  DIV_INT_32_16     = 3'h4;
  localparam logic [2:0]  DIV_INT_32_32     = 3'h5;
endpackage : rld_pkg

// ===== rld_div_step.sv
// One iteration of the restoring divider: a few quotient bits per call
`timescale 1ns/1ns
module rld_div_step #(
  parameter int STEP_BITS = 6
) (
  input  wire logic [31:0] rem_in,
  input  wire logic [31:0] quo_in,
  input  wire logic [31:0] divisor,
  input  wire logic [5:0]  shifts,
  output logic      [31:0] rem_out,
  output logic      [31:0] quo_out
);
  // Rem/quotient shift pair; the long partial remainder is 33 bits to keep the carry
  always_comb begin
    logic [32:0] r;
    logic [31:0] q;
    r = {1'b0, rem_in};
    q = quo_in;
    // Passes past the last dividend bit must not shift, or the finished pair would be spoiled
    for (int i = 0; i < STEP_BITS; i++) begin
      if (i < int'(shifts)) begin
        r = {r[31:0], q[31]};
        q = {q[30:0], 1'b0};
        if (r >= {1'b0, divisor}) begin
          r = r - {1'b0, divisor};
          q[0] = 1'b1;
        end
      end
    end
    rem_out = r[31:0];
    quo_out = q;
  end
endmodule : rld_div_step

// ===== rld_core_sva.sv
// Assertion checker for the repeat loop and divide core
`timescale 1ns/1ns
module rld_core_sva (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        REG_WR,
  input wire logic        REPEAT_VALID,
  input wire logic        REPEAT_USE_REG,
  input wire logic        TARGET_DONE,
  input wire logic        IRQ_ENTRY,
  input wire logic        IRQ_RETURN,
  input wire logic        STACK_LOOP_ACTIVE,
  input wire logic        PC_HOLD,
  input wire logic        FETCH_BUBBLE,
  input wire logic        LOOP_ACTIVE,
  input wire logic        DIV_VALID,
  input wire logic        DIV_FIRST,
  input wire logic        WREG_WE,
  input wire logic        MATH_TRAP,
  input wire logic [19:0] REPEAT_LITERAL,
  input wire logic [31:0] DIV_DIVISOR,
  input wire logic [3:0]  DIV_DEST,
  input wire logic [3:0]  WREG_QUO_ADDR,
  input wire logic [3:0]  WREG_REM_ADDR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  hold_stays_a: assert property (PC_HOLD && !TARGET_DONE && !IRQ_ENTRY && !REPEAT_VALID && !REG_WR |=> PC_HOLD)
    else $error("pc hold dropped while count stands");
  start_active_a: assert property (REPEAT_VALID && !REPEAT_USE_REG && REPEAT_LITERAL != 0 && !IRQ_ENTRY |=> LOOP_ACTIVE)
    else $error("nonzero count left flag clear");
  zero_count_a: assert property (REPEAT_VALID && !REPEAT_USE_REG && REPEAT_LITERAL == 0 |=> !LOOP_ACTIVE)
    else $error("zero count set flag");
  irq_stack_a: assert property (IRQ_ENTRY && !REPEAT_VALID |=> !LOOP_ACTIVE && STACK_LOOP_ACTIVE == $past(LOOP_ACTIVE))
    else $error("flag not stacked and cleared");
  bubble_pair_a: assert property (IRQ_RETURN |=> FETCH_BUBBLE [*2] ##1 !FETCH_BUBBLE)
    else $error("bubble count wrong");
  wb_addr_a: assert property (DIV_VALID && DIV_DIVISOR != 0 |=> WREG_WE && WREG_QUO_ADDR == $past(DIV_DEST)
    && WREG_REM_ADDR == $past(DIV_DEST) + 4'h1)
    else $error("write-back registers wrong");
  div_zero_a: assert property (DIV_VALID && DIV_FIRST && DIV_DIVISOR == 0 |=> MATH_TRAP && !WREG_WE)
    else $error("zero divisor not trapped");
  loop_end_a: assert property ($fell(LOOP_ACTIVE) |-> $past(TARGET_DONE || IRQ_ENTRY || REG_WR || REPEAT_VALID))
    else $error("flag dropped without cause");
endmodule : rld_core_sva
bind rld_core rld_core_sva i_rld_core_sva (.*);

// ===== rld_pipe_model.sv
// Pipeline model that retires the held target instruction
`timescale 1ns/1ns
module rld_pipe_model (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pc_hold,
  input  wire logic go,
  input  wire logic slow,
  output logic      target_done
);
  logic ph_q;
  logic ph_d;
  always_comb begin
    ph_d = srst ? 1'b0 : ~ph_q;
  end
  always_ff @(posedge clk) begin
    ph_q <= ph_d;
  end
  // Only a plain target is modelled, never flow control; slow mode retires every other cycle
  assign target_done = pc_hold & go & (~slow | ph_q);
endmodule : rld_pipe_model

// ===== rld_core_test.sv
// Self-checking testbench for the repeat loop and divide core
`timescale 1ns/1ns
module rld_core_test;
  logic CLK = 0, SRST = 1, REG_WR = 0, REG_RD = 0, REPEAT_VALID = 0, REPEAT_USE_REG = 0, IRQ_ENTRY = 0;
  logic IRQ_RETURN = 0, STACKED_LOOP_ACTIVE = 0, DIV_VALID = 0, DIV_SIGNED = 0, DIV_FIRST = 0, go = 0, slow = 0;
  logic TARGET_DONE, STACK_LOOP_ACTIVE, PC_HOLD, FETCH_BUBBLE, LOOP_ACTIVE, WREG_WE, MATH_TRAP;
  logic [3:0]  REG_ADDR = 0, DIV_DEST = 0, WREG_QUO_ADDR, WREG_REM_ADDR;
  logic [2:0]  DIV_MODE = 0;
  logic [19:0] REPEAT_LITERAL = 0;
  logic [31:0] REG_WDATA = 0, REPEAT_REG_VALUE = 0, DIV_DIVIDEND = 0, DIV_DIVISOR = 0, DIV_REM_IN = 0;
  logic [31:0] DIV_QUO_IN = 0, REG_RDATA, WREG_QUO_DATA, WREG_REM_DATA;
  int n_errors = 0, n_checks = 0, n_td = 0, t0;
  rld_core i_rld_core (.CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REPEAT_VALID,
    .REPEAT_USE_REG, .REPEAT_LITERAL, .REPEAT_REG_VALUE, .TARGET_DONE, .IRQ_ENTRY, .IRQ_RETURN,
    .STACKED_LOOP_ACTIVE, .STACK_LOOP_ACTIVE, .PC_HOLD, .FETCH_BUBBLE, .LOOP_ACTIVE, .DIV_VALID, .DIV_MODE,
    .DIV_SIGNED, .DIV_FIRST, .DIV_DIVIDEND, .DIV_DIVISOR, .DIV_REM_IN, .DIV_QUO_IN, .DIV_DEST, .WREG_WE,
    .WREG_QUO_ADDR, .WREG_REM_ADDR, .WREG_QUO_DATA, .WREG_REM_DATA, .MATH_TRAP);
  rld_pipe_model i_rld_pipe_model (.clk(CLK), .srst(SRST), .pc_hold(PC_HOLD), .go, .slow, .target_done(TARGET_DONE));
  initial forever #4 CLK = ~CLK;
  always @(posedge CLK) if (TARGET_DONE === 1'b1) n_td <= n_td + 1;
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge CLK);
    REG_WR    <= 1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 0;
  endtask : wr
  task automatic rd(string name, logic [3:0] a, logic [31:0] exp);
    @(posedge CLK);
    REG_RD   <= 1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 0;
    #1 chk(name, REG_RDATA, exp);
  endtask : rd
  task automatic rep(logic ureg, logic [19:0] lit, logic [31:0] rv);
    @(posedge CLK);
    REPEAT_VALID     <= 1;
    REPEAT_USE_REG   <= ureg;
    REPEAT_LITERAL   <= lit;
    REPEAT_REG_VALUE <= rv;
    @(posedge CLK);
    REPEAT_VALID <= 0;
    #1;
  endtask : rep
  // Interrupt entry or return strobe; leaves time just after the taking edge
  task automatic irq(bit ret);
    @(posedge CLK);
    if (ret) begin
      IRQ_RETURN <= 1;
    end else begin
      IRQ_ENTRY <= 1;
    end
    @(posedge CLK);
    IRQ_RETURN <= 0;
    IRQ_ENTRY  <= 0;
    #1;
  endtask : irq
  task automatic div(logic [2:0] m, logic [3:0] d, logic [31:0] dv);
    @(posedge CLK);
    DIV_VALID    <= 1;
    DIV_MODE     <= m;
    DIV_SIGNED   <= m[0];
    DIV_FIRST    <= 1;
    DIV_DEST     <= d;
    DIV_DIVIDEND <= 100;
    DIV_DIVISOR  <= dv;
    @(posedge CLK);
    DIV_VALID <= 0;
    #1;
  endtask : div
  // Full divide: each pass sees the loop count it would have inside the repeat, and the pair is fed back
  task automatic div_full(logic [2:0] m, logic s, logic [31:0] a, logic [31:0] b, logic [31:0] eq, logic [31:0] er);
    int          n;
    logic [31:0] q;
    logic [31:0] r;
    n = (m == rld_pkg::DIV_FRAC_32_32 || m == rld_pkg::DIV_INT_32_32) ? rld_pkg::ITER_LONG : rld_pkg::ITER_SHORT;
    q = 32'h0000_0000;
    r = 32'h0000_0000;
    for (int k = 0; k < n; k++) begin
      wr(rld_pkg::ADDR_LOOP_COUNTER, 32'(n - 1 - k));
      DIV_VALID    <= 1;
      DIV_MODE     <= m;
      DIV_SIGNED   <= s;
      DIV_FIRST    <= (k == 0);
      DIV_DIVIDEND <= a;
      DIV_DIVISOR  <= b;
      DIV_REM_IN   <= r;
      DIV_QUO_IN   <= q;
      DIV_DEST     <= 4'h6;
      @(posedge CLK);
      DIV_VALID <= 0;
      #1;
      q = WREG_QUO_DATA;
      r = WREG_REM_DATA;
    end
    chk("quotient", q, eq);
    chk("remainder", r, er);
  endtask : div_full
  // Outputs are looked at 1 ns after each edge, once they have settled
  task automatic drain();
    go <= 1;
    for (int i = 0; i < 100; i++) begin
      @(posedge CLK);
      #1;
      if (LOOP_ACTIVE === 1'b0) break;
    end
    go <= 0;
  endtask : drain
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge CLK);
    SRST <= 0;
    rep(0, 20'h3, 0);
    rd("counter", 4'h0, 32'h3);
    wr(4'h4, 0);
    rd("status", 4'h4, 32'h10);
    rd("unmapped", 4'hc, 0);
    t0 = n_td;
    slow <= 1;
    drain();
    chk("runs", n_td - t0 + 1, 4);
    rd("counter end", 4'h0, 0);
    t0 = n_td;
    rep(0, 0, 0);
    chk("zero flag", LOOP_ACTIVE, 0);
    drain();
    chk("zero runs", n_td - t0, 0);
    $display("test repeat done");
    rep(1, 0, 32'h0010_0002);
    rd("reg count", 4'h0, 32'h0010_0002);
    irq(0);
    chk("stacked", {STACK_LOOP_ACTIVE, LOOP_ACTIVE}, 2'b10);
    wr(4'h0, 0);
    STACKED_LOOP_ACTIVE <= 1;
    irq(1);
    chk("bubble", FETCH_BUBBLE, 1);
    @(posedge CLK) #1 chk("bubble", FETCH_BUBBLE, 1);
    @(posedge CLK) #1 chk("early end", {FETCH_BUBBLE, LOOP_ACTIVE}, 0);
    rep(0, 20'h2, 0);
    irq(0);
    rd("saved", 4'h0, 32'h2);
    wr(4'h0, 32'h2);
    irq(1);
    chk("resume", LOOP_ACTIVE, 1);
    slow <= 0;
    drain();
    $display("test interrupt done");
    for (int m = 0; m < 6; m++) begin
      div(3'(m), 4'(2 * m), 7);
      chk("wb", {WREG_WE, WREG_REM_ADDR, WREG_QUO_ADDR}, {1'b1, 4'(2 * m + 1), 4'(2 * m)});
    end
    div(rld_pkg::DIV_INT_16_16, 4'h3, 0);
    chk("trap", {MATH_TRAP, WREG_WE}, 2'b10);
    rd("div err", 4'h8, 32'h1);
    wr(4'h8, 0);
    rd("div err clr", 4'h8, 0);
    div_full(rld_pkg::DIV_INT_16_16, 1'b1, 32'h0000_ff9c, 32'h0000_0007, 32'hffff_fff2, 32'hffff_fffe);
    div_full(rld_pkg::DIV_INT_32_32, 1'b0, 32'h0000_0064, 32'h0000_0007, 32'h0000_000e, 32'h0000_0002);
    $display("test divide done");
    complete_run();
  end
endmodule : rld_core_test
